// >>> logic/amsrc_flash_dev.sv
// Purpose: memory end of the link: address width, soft reset, status
// Assumes: link pins are synchronised here; mode 0 serial clock
// Notes:   no array; reads report their address only
`timescale 1ns/10ps
module amsrc_flash_dev
	import amsrc_pkg::*;
(
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          resetn,
	// Link
	amsrc_link_if.dev          link,
	// Mode and straps
	input  wire amsrc_lanes_t  ioLanes,
	input  wire logic          hwResetN,
	input  wire logic [7:0]    nvStatusIn,
	// Status to user side
	output logic [7:0]         statusOut,
	output logic               fourByteOut,
	output logic               xipOut,
	output logic [31:0]        addrOut,
	output logic               addrValid,
	output logic               addrWide
);
	typedef enum logic [2:0] {
		D_CMD, D_ADDR, D_MODE, D_DATA, D_OUT, D_SKIP
	} amsrc_dstate_t;

	typedef struct packed {
		logic          csS1;
		logic          csS2;
		logic          csPrev;
		logic          ckS1;
		logic          ckS2;
		logic          ckPrev;
		logic [3:0]    dqS1;
		logic [3:0]    dqS2;
		logic          hwS1;
		logic          hwS2;
		amsrc_dstate_t st;
		logic [7:0]    op;
		logic [31:0]   sh;
		logic [5:0]    bits;
		logic [5:0]    need;
		logic          extra;
		logic [7:0]    outSh;
		logic [7:0]    sr;
		logic          nvLoaded;
		logic          fourByte;
		logic          xip;
		logic          rstArmed;
		logic [3:0]    dqOut;
		logic [3:0]    dqOe;
		logic [31:0]   addr;
		logic          addrValid;
		logic          addrWide;
	} amsrc_dev_t;

	amsrc_dev_t r_reg;
	amsrc_dev_t r_next;

	function automatic logic [31:0] shiftIn(
		input logic [31:0] s,
		input logic [3:0]  d,
		input logic [2:0]  l
	);
		unique case (l)
			3'h2:    return {s[29:0], d[1:0]};
			3'h4:    return {s[27:0], d};
			default: return {s[30:0], d[0]};
		endcase
	endfunction : shiftIn

	// Returns enable, data and the rotated shifter
	function automatic logic [15:0] outStep(
		input logic [7:0] o,
		input logic [2:0] l
	);
		unique case (l)
			3'h2:    return {4'h3, 2'b00, o[7:6], o[5:0], o[7:6]};
			3'h4:    return {4'hf, o[7:4], o[3:0], o[7:4]};
			default: return {4'h2, 2'b00, o[7], 1'b0, o[6:0], o[7]};
		endcase
	endfunction : outStep

	always_comb begin
		logic [2:0]  l;
		logic        rise;
		logic        fall;
		logic        csRise;
		logic        quad;
		logic        done;
		logic        ok;
		logic        softRst;
		logic [31:0] sh;
		logic [15:0] step;
		l       = 3'h1;
		rise    = 1'b0;
		fall    = 1'b0;
		csRise  = 1'b0;
		quad    = 1'b0;
		done    = 1'b0;
		ok      = 1'b0;
		softRst = 1'b0;
		sh      = '0;
		step    = '0;
		r_next  = r_reg;
		r_next.csS1   = link.csN;
		r_next.csS2   = r_reg.csS1;
		r_next.csPrev = r_reg.csS2;
		r_next.ckS1   = link.sclk;
		r_next.ckS2   = r_reg.ckS1;
		r_next.ckPrev = r_reg.ckS2;
		r_next.dqS1   = link.dq;
		r_next.dqS2   = r_reg.dqS1;
		r_next.hwS1   = hwResetN;
		r_next.hwS2   = r_reg.hwS1;
		r_next.addrValid = 1'b0;

		rise   = r_reg.ckS2 & ~r_reg.ckPrev & ~r_reg.csS2;
		fall   = ~r_reg.ckS2 & r_reg.ckPrev & ~r_reg.csS2;
		csRise = r_reg.csS2 & ~r_reg.csPrev;
		quad   = (r_reg.op == CMD_QIOR) || (r_reg.op == CMD_QIOR4);
		// Instruction phase always follows the interface width
		l = (r_reg.st == D_CMD || !quad) ? laneCnt(ioLanes) : 3'h4;
		sh   = shiftIn(r_reg.sh, r_reg.dqS2, l);
		done = (r_reg.bits + 6'(l)) == r_reg.need;
		// Persistent bits come back from the user store after power-up
		if (!r_reg.nvLoaded) begin
			r_next.nvLoaded = 1'b1;
			r_next.sr       = nvStatusIn & SR_NV_MASK;
		end
		if (rise && r_reg.st != D_OUT && r_reg.st != D_SKIP) begin
			r_next.sh   = sh;
			r_next.bits = r_reg.bits + 6'(l);
		end
		if (rise) begin
			unique case (r_reg.st)
				D_CMD: begin
					// Opcode is always one byte, whatever need holds
					if (r_reg.bits + 6'(l) == DATA_BITS) begin
						r_next.op   = sh[7:0];
						r_next.bits = '0;
						r_next.st   = D_SKIP;
						case (sh[7:0])
							CMD_READ, CMD_QIOR: begin
								r_next.need = r_reg.fourByte ? ADDR_BITS4
									: ADDR_BITS3;
								r_next.st   = D_ADDR;
							end
							CMD_READ4, CMD_QIOR4: begin
								r_next.need = ADDR_BITS4;
								r_next.st   = D_ADDR;
							end
							CMD_RDSR: begin
								r_next.outSh = r_reg.sr;
								r_next.st    = D_OUT;
							end
							CMD_WRSR: begin
								r_next.need = DATA_BITS;
								r_next.st   = D_DATA;
							end
							default: r_next.st = D_SKIP;
						endcase
					end
				end
				D_ADDR: begin
					if (done) begin
						r_next.addr = (r_reg.need == ADDR_BITS4) ? sh
							: {8'h00, sh[23:0]};
						r_next.addrWide  = r_reg.need == ADDR_BITS4;
						r_next.addrValid = 1'b1;
						r_next.bits      = '0;
						r_next.need      = DATA_BITS;
						r_next.st        = quad ? D_MODE : D_SKIP;
					end
				end
				D_MODE: begin
					if (done) begin
						// Any mode byte other than Ax, all-ones included
						r_next.xip = sh[7:4] == XIP_KEY;
						r_next.st  = D_SKIP;
					end
				end
				D_DATA: if (done) r_next.st = D_SKIP;
				D_OUT: r_next.extra = 1'b1;
				D_SKIP: r_next.extra = 1'b1;
			endcase
		end
		// Output changes on the falling edge, host samples as the clock next falls
		if (fall && r_reg.st == D_OUT) begin
			step = outStep(r_reg.outSh, l);
			r_next.dqOe  = step[15:12];
			r_next.dqOut = step[11:8];
			r_next.outSh = step[7:0];
		end
		if (csRise) begin
			ok = r_reg.st == D_SKIP && !r_reg.extra;
			r_next.dqOe     = '0;
			r_next.bits     = '0;
			r_next.extra    = 1'b0;
			r_next.rstArmed = 1'b0;
			r_next.st       = D_CMD;
			// Ones over a wide address end the mode; else resume at address
			if (r_reg.xip && r_reg.st == D_MODE && r_reg.bits == '0
				&& r_reg.sh == '1) begin
				r_next.xip = 1'b0;
			end else if (r_reg.xip) begin
				r_next.st   = D_ADDR;
				r_next.need = (r_reg.op == CMD_QIOR4 || r_reg.fourByte)
					? ADDR_BITS4 : ADDR_BITS3;
			end
			if (ok) begin
				case (r_reg.op)
					CMD_WREN: r_next.sr[SR_WEL] = 1'b1;
					CMD_WRDI: r_next.sr[SR_WEL] = 1'b0;
					CMD_EN4B: r_next.fourByte = 1'b1;
					CMD_EX4B: r_next.fourByte = 1'b0;
					CMD_RSTEN: r_next.rstArmed = 1'b1;
					CMD_RST: softRst = r_reg.rstArmed;
					CMD_WRSR: begin
						if (r_reg.sr[SR_WEL]) begin
							r_next.sr = r_reg.sh[7:0] & SR_NV_MASK;
						end
					end
					default: ;
				endcase
			end
		end
		if (softRst || !r_reg.hwS2) begin
			r_next.fourByte = 1'b0;
			r_next.xip      = 1'b0;
			r_next.rstArmed = 1'b0;
			r_next.sr       = r_next.sr & SR_NV_MASK;
			r_next.st       = D_CMD;
			r_next.bits     = '0;
			r_next.dqOe     = '0;
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			r_reg        <= '0;
			r_reg.csS1   <= 1'b1;
			r_reg.csS2   <= 1'b1;
			r_reg.csPrev <= 1'b1;
			r_reg.hwS1   <= 1'b1;
			r_reg.hwS2   <= 1'b1;
			r_reg.sr     <= SR_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	assign link.devDqOut = r_reg.dqOut;
	assign link.devDqOe  = r_reg.dqOe;
	assign statusOut     = r_reg.sr;
	assign fourByteOut   = r_reg.fourByte;
	assign xipOut        = r_reg.xip;
	assign addrOut       = r_reg.addr;
	assign addrValid     = r_reg.addrValid;
	assign addrWide      = r_reg.addrWide;
endmodule : amsrc_flash_dev

// >>> logic/amsrc_pkg.sv
// Purpose: shared constants and types for both flash link ends
// Assumes: serial clock mode 0, one status register
// Notes:   times are in ns; cycle counts derive from the core clock
package amsrc_pkg;
	localparam logic [7:0] CMD_WRSR  = 8'h01;
	localparam logic [7:0] CMD_READ  = 8'h03;
	localparam logic [7:0] CMD_WRDI  = 8'h04;
	localparam logic [7:0] CMD_RDSR  = 8'h05;
	localparam logic [7:0] CMD_WREN  = 8'h06;
	localparam logic [7:0] CMD_READ4 = 8'h13;
	localparam logic [7:0] CMD_RSTEN = 8'h66;
	localparam logic [7:0] CMD_RST   = 8'h99;
	localparam logic [7:0] CMD_EN4B  = 8'hb7;
	localparam logic [7:0] CMD_EX4B  = 8'he9;
	localparam logic [7:0] CMD_QIOR  = 8'heb;
	localparam logic [7:0] CMD_QIOR4 = 8'hec;

	// Upper six bits persist, write-enable and busy bits do not
	localparam logic [7:0] SR_NV_MASK = 8'hfc;
	localparam int         SR_WEL     = 1;
	localparam logic [7:0] SR_RESET   = 8'h00;

	localparam logic [3:0] XIP_KEY     = 4'ha;
	localparam logic [7:0] XIP_MODE_ON = 8'ha0;
	localparam int         XIP_EXIT_CLKS = 8;
	localparam logic [5:0] XIP_EXIT_BITS = 6'(XIP_EXIT_CLKS * 4);
	localparam logic [5:0] ADDR_BITS3 = 6'h18;
	localparam logic [5:0] ADDR_BITS4 = 6'h20;
	localparam logic [5:0] DATA_BITS  = 6'h08;

	localparam int         CORE_NS   = 40;
	localparam int         SCLK_NS   = 320;
	localparam int         CS_GAP_NS = 320;
	localparam logic [3:0] SCLK_CYC  = 4'(SCLK_NS / CORE_NS);
	localparam logic [3:0] SCLK_HIGH = 4'(SCLK_NS / CORE_NS / 2);
	localparam logic [3:0] GAP_CYC   = 4'((CS_GAP_NS + CORE_NS - 1) / CORE_NS);

	typedef enum logic [1:0] {LN1, LN2, LN4} amsrc_lanes_t;
	typedef enum logic [3:0] {
		HC_WREN, HC_WRDI, HC_EN4B, HC_EX4B, HC_RESET, HC_WRSR,
		HC_RDSR, HC_READ, HC_READ4, HC_XIP, HC_XIPEXIT
	} amsrc_hcmd_t;

	function automatic logic [2:0] laneCnt(input amsrc_lanes_t l);
		unique case (l)
			LN1:     return 3'h1;
			LN2:     return 3'h2;
			LN4:     return 3'h4;
			default: return 3'h1;
		endcase
	endfunction : laneCnt
endpackage : amsrc_pkg

// >>> logic/amsrc_link_if.sv
// Purpose: serial flash link between controller and memory end
// Assumes: each wire is pulled high when nobody drives it
// Notes:   wire level is resolved here from the two enables
`timescale 1ns/10ps
interface amsrc_link_if;
	logic       sclk;
	logic       csN;
	logic [3:0] hostDqOut;
	logic [3:0] hostDqOe;
	logic [3:0] devDqOut;
	logic [3:0] devDqOe;
	logic [3:0] dq;

	assign dq = (hostDqOe & hostDqOut) | (devDqOe & devDqOut)
		| ~(hostDqOe | devDqOe);

	modport host (output sclk, csN, hostDqOut, hostDqOe, input dq);
	modport dev  (input sclk, csN, dq, output devDqOut, devDqOe);
endinterface : amsrc_link_if

// >>> logic/amsrc_flash_host.sv
// Purpose: controller end: turns user commands into link frames
// Assumes: memory end echoes data within five core cycles of a fall
// Notes:   address width and continuous mode are tracked locally
`timescale 1ns/10ps
module amsrc_flash_host
	import amsrc_pkg::*;
(
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          resetn,
	// Link
	amsrc_link_if.host         link,
	// Requests
	input  wire logic          reqValid,
	input  wire amsrc_hcmd_t   reqCmd,
	input  wire logic [31:0]   reqAddr,
	input  wire logic [7:0]    reqData,
	input  wire amsrc_lanes_t  reqLanes,
	// Answers
	output logic               reqReady,
	output logic               done,
	output logic [7:0]         rdByte,
	output logic               fourByteOut,
	output logic               xipOut
);
	typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} amsrc_hstate_t;

	typedef struct packed {
		logic [3:0]   opLeft;
		logic [7:0]   op;
		logic [5:0]   bodyLeft;
		logic [39:0]  body;
		amsrc_lanes_t bodyL;
		logic [3:0]   rdLeft;
		logic         last;
	} amsrc_frame_t;

	typedef struct packed {
		amsrc_hstate_t st;
		amsrc_hcmd_t   cmd;
		logic [1:0]    step;
		logic [3:0]    cnt;
		amsrc_frame_t  f;
		logic          rdNow;
		logic [31:0]   addr;
		logic [7:0]    data;
		amsrc_lanes_t  lanes;
		logic          sclk;
		logic          csN;
		logic [3:0]    dqOut;
		logic [3:0]    dqOe;
		logic [3:0]    dqS1;
		logic [3:0]    dqS2;
		logic [7:0]    rd;
		logic          ready;
		logic          done;
		logic [7:0]    rdByte;
		logic          four;
		logic          xip;
	} amsrc_host_t;

	amsrc_host_t r_reg;
	amsrc_host_t r_next;

	function automatic amsrc_frame_t frameOf(
		input amsrc_hcmd_t  c,
		input logic [1:0]   s,
		input logic [31:0]  a,
		input logic [7:0]   d,
		input logic         four,
		input logic         xip,
		input amsrc_lanes_t ln
	);
		amsrc_frame_t f;
		logic         wide;
		logic [7:0]   m;
		f = '{opLeft: 4'h8, op: 8'h00, bodyLeft: 6'h00, body: 40'h0,
			bodyL: ln, rdLeft: 4'h0, last: 1'b1};
		wide = four || c == HC_READ4;
		m    = (c == HC_XIP) ? XIP_MODE_ON : 8'h00;
		unique case (c)
			HC_WREN: f.op = CMD_WREN;
			HC_WRDI: f.op = CMD_WRDI;
			HC_EN4B: f.op = CMD_EN4B;
			HC_EX4B: f.op = CMD_EX4B;
			HC_RDSR: begin
				f.op     = CMD_RDSR;
				f.rdLeft = 4'h8;
			end
			HC_WRSR: begin
				f.last = s == 2'h1;
				f.op   = (s == 2'h0) ? CMD_WREN : CMD_WRSR;
				if (s == 2'h1) begin
					f.bodyLeft = DATA_BITS;
					f.body     = {d, 32'h0};
				end
			end
			HC_RESET: begin
				f.last = s == 2'h2;
				f.op   = (s == 2'h1) ? CMD_RSTEN : CMD_RST;
				if (s == 2'h0) begin
					f.opLeft   = 4'h0;
					f.bodyLeft = XIP_EXIT_BITS;
					f.body     = '1;
					f.bodyL    = LN4;
				end
			end
			HC_XIPEXIT: begin
				f.opLeft   = 4'h0;
				f.bodyLeft = XIP_EXIT_BITS;
				f.body     = '1;
				f.bodyL    = LN4;
			end
			HC_READ, HC_READ4, HC_XIP: begin
				f.op = (c == HC_READ4) ? CMD_READ4
					: (c == HC_XIP) ? CMD_QIOR : CMD_READ;
				if (c == HC_XIP) begin
					f.opLeft = xip ? 4'h0 : 4'h8;
					f.bodyL  = LN4;
				end
				f.body     = wide ? {a, m} : {a[23:0], m, 8'h00};
				f.bodyLeft = (wide ? ADDR_BITS4 : ADDR_BITS3)
					+ ((c == HC_XIP) ? DATA_BITS : 6'h00);
			end
			default: f.op = CMD_WRDI;
		endcase
		return f;
	endfunction : frameOf

	always_comb begin
		logic [2:0] lo;
		logic [2:0] lb;
		logic [1:0] nStep;
		lo     = laneCnt(r_reg.lanes);
		lb     = laneCnt(r_reg.f.bodyL);
		nStep  = r_reg.step + 2'h1;
		r_next = r_reg;
		r_next.dqS1 = link.dq;
		r_next.dqS2 = r_reg.dqS1;
		r_next.done = 1'b0;
		unique case (r_reg.st)
			H_IDLE: begin
				if (reqValid) begin
					r_next.cmd   = reqCmd;
					r_next.addr  = reqAddr;
					r_next.data  = reqData;
					r_next.lanes = reqLanes;
					// Exit frame is needed only when continuous mode may run
					r_next.step  = (reqCmd == HC_RESET && !r_reg.xip)
						? 2'h1 : 2'h0;
					r_next.f     = frameOf(reqCmd, r_next.step, reqAddr,
						reqData, r_reg.four, r_reg.xip, reqLanes);
					r_next.ready = 1'b0;
					r_next.csN   = 1'b0;
					r_next.cnt   = '0;
					r_next.st    = H_RUN;
				end
			end
			H_RUN: begin
				r_next.cnt = r_reg.cnt + 4'h1;
				if (r_reg.cnt == 4'h0) begin
					r_next.rdNow = 1'b0;
					if (r_reg.f.opLeft != 4'h0) begin
						r_next.dqOe     = (lo == 3'h4) ? 4'hf
							: (lo == 3'h2) ? 4'h3 : 4'h1;
						r_next.dqOut    = r_reg.f.op[7:4] >> (3'h4 - lo);
						r_next.f.op     = r_reg.f.op << lo;
						r_next.f.opLeft = r_reg.f.opLeft - 4'(lo);
					end else if (r_reg.f.bodyLeft != 6'h00) begin
						r_next.dqOe       = (lb == 3'h4) ? 4'hf
							: (lb == 3'h2) ? 4'h3 : 4'h1;
						r_next.dqOut      = r_reg.f.body[39:36] >> (3'h4 - lb);
						r_next.f.body     = r_reg.f.body << lb;
						r_next.f.bodyLeft = r_reg.f.bodyLeft - 6'(lb);
					end else if (r_reg.f.rdLeft != 4'h0) begin
						r_next.dqOe  = '0;
						r_next.rdNow = 1'b1;
					end else begin
						r_next.dqOe = '0;
						r_next.csN  = 1'b1;
						r_next.cnt  = '0;
						r_next.st   = H_GAP;
					end
				end
				if (r_reg.cnt == SCLK_HIGH) begin
					r_next.sclk = 1'b1;
				end
				// Late sample covers both synchroniser delays
				if (r_reg.cnt == SCLK_CYC - 4'h1) begin
					r_next.sclk = 1'b0;
					r_next.cnt  = '0;
					if (r_reg.rdNow) begin
						r_next.rd = (lo == 3'h4) ? {r_reg.rd[3:0], r_reg.dqS2}
							: (lo == 3'h2) ? {r_reg.rd[5:0], r_reg.dqS2[1:0]}
							: {r_reg.rd[6:0], r_reg.dqS2[1]};
						r_next.f.rdLeft = r_reg.f.rdLeft - 4'(lo);
					end
				end
			end
			H_GAP: begin
				r_next.cnt = r_reg.cnt + 4'h1;
				if (r_reg.cnt == GAP_CYC - 4'h1) begin
					r_next.cnt = '0;
					if (r_reg.f.last) begin
						r_next.st     = H_IDLE;
						r_next.ready  = 1'b1;
						r_next.done   = 1'b1;
						r_next.rdByte = r_reg.rd;
						case (r_reg.cmd)
							HC_EN4B: r_next.four = 1'b1;
							HC_EX4B: r_next.four = 1'b0;
							HC_XIP: r_next.xip = 1'b1;
							HC_XIPEXIT: r_next.xip = 1'b0;
							HC_RESET: begin
								r_next.four = 1'b0;
								r_next.xip  = 1'b0;
							end
							default: ;
						endcase
					end else begin
						r_next.step = nStep;
						r_next.f    = frameOf(r_reg.cmd, nStep, r_reg.addr,
							r_reg.data, r_reg.four, r_reg.xip, r_reg.lanes);
						r_next.csN  = 1'b0;
						r_next.st   = H_RUN;
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			r_reg       <= '0;
			r_reg.csN   <= 1'b1;
			r_reg.ready <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign link.sclk      = r_reg.sclk;
	assign link.csN       = r_reg.csN;
	assign link.hostDqOut = r_reg.dqOut;
	assign link.hostDqOe  = r_reg.dqOe;
	assign reqReady       = r_reg.ready;
	assign done           = r_reg.done;
	assign rdByte         = r_reg.rdByte;
	assign fourByteOut    = r_reg.four;
	assign xipOut         = r_reg.xip;
endmodule : amsrc_flash_host

// >>> tb/amsrc_assertions.sv
// Purpose: wire-level checks on the flash link between both ends
// Assumes: one core clock domain, link pins seen as plain inputs
// Notes:   timing figures follow the host's divider of eight
`timescale 1ns/10ps
module amsrc_assertions (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       resetn,
	// Link
	input wire logic       sclk,
	input wire logic       csN,
	input wire logic [3:0] hostDqOut,
	input wire logic [3:0] hostDqOe,
	input wire logic [3:0] devDqOut,
	input wire logic [3:0] devDqOe,
	input wire logic [3:0] dq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	AST_SCLK_IDLE: assert property (csN |-> !sclk)
		else $error("serial clock high while deselected");
	AST_HOST_RELEASE: assert property (csN |-> hostDqOe == 4'h0)
		else $error("host drives data while deselected");
	AST_NO_CLASH: assert property ((hostDqOe & devDqOe) == 4'h0)
		else $error("both ends drive one data wire");
	AST_LANE_SHAPE: assert property (hostDqOe inside {4'h0, 4'h1, 4'h3,
		4'hf})
		else $error("host enables an odd set of wires");
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*3] ##1 !sclk)
		else $error("serial clock high phase not three cycles");
	AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk[*4])
		else $error("serial clock low phase too short");
	AST_FRAME_START: assert property ($fell(csN) |-> !sclk[*4])
		else $error("serial clock rises too soon after select");
	AST_HOLD_HIGH: assert property (sclk && $past(sclk) |->
		$stable(hostDqOut & hostDqOe))
		else $error("host data moved while serial clock high");
	AST_CS_GAP: assert property ($rose(csN) |-> csN[*8])
		else $error("deselect gap shorter than eight cycles");
	AST_DEV_QUIET: assert property (csN[*6] |-> devDqOe == 4'h0)
		else $error("memory end drives data after deselect");
endmodule : amsrc_assertions

// >>> tb/tb.sv
// Purpose: drives both link ends and compares with a reference model
// Assumes: host and memory end share one core clock
// Notes:   wire count of the memory end follows each request
`timescale 1ns/10ps
module tb;
	import amsrc_pkg::*;

	logic         core_clk = 1'b0;
	logic         resetn = 1'b0;
	logic         reqValid = 1'b0;
	amsrc_hcmd_t  reqCmd = HC_WREN;
	logic [31:0]  reqAddr = 32'h0;
	logic [7:0]   reqData = 8'h0;
	amsrc_lanes_t reqLanes = LN1;
	amsrc_lanes_t ioLanes = LN1;
	logic         hwResetN = 1'b1;
	logic [7:0]   nvStatusIn = 8'h0;
	logic         reqReady, done, hFour, hXip, dFour, dXip;
	logic         addrValid, addrWide;
	logic [7:0]   rdByte, statusOut;
	logic [31:0]  addrOut;
	logic [31:0]  rnd = 32'ha0c0;
	logic         fourB, xipM, wel;
	logic [7:0]   nvM;
	int           errors = 0;
	int           checks = 0;
	int           addrSeen = 0;

	always #20 core_clk = ~core_clk;

	// Counts address pulses so each read proves exactly one
	always @(posedge core_clk) begin
		if (addrValid)
			addrSeen++;
	end

	amsrc_link_if link ();
	amsrc_flash_host i_amsrc_flash_host (.core_clk(core_clk),
		.resetn(resetn), .link(link), .reqValid(reqValid),
		.reqCmd(reqCmd), .reqAddr(reqAddr), .reqData(reqData),
		.reqLanes(reqLanes), .reqReady(reqReady), .done(done),
		.rdByte(rdByte), .fourByteOut(hFour), .xipOut(hXip));
	amsrc_flash_dev i_amsrc_flash_dev (.core_clk(core_clk),
		.resetn(resetn), .link(link), .ioLanes(ioLanes),
		.hwResetN(hwResetN), .nvStatusIn(nvStatusIn),
		.statusOut(statusOut), .fourByteOut(dFour), .xipOut(dXip),
		.addrOut(addrOut), .addrValid(addrValid), .addrWide(addrWide));
	amsrc_assertions i_amsrc_assertions (.core_clk(core_clk),
		.resetn(resetn), .sclk(link.sclk), .csN(link.csN),
		.hostDqOut(link.hostDqOut), .hostDqOe(link.hostDqOe),
		.devDqOut(link.devDqOut), .devDqOe(link.devDqOe), .dq(link.dq));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic close_out;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	task automatic cmp_all;
		chk("hostFour", 32'(hFour), 32'(fourB));
		chk("devFour", 32'(dFour), 32'(fourB));
		chk("hostXip", 32'(hXip), 32'(xipM));
		chk("devXip", 32'(dXip), 32'(xipM));
		chk("status", 32'(statusOut), 32'({nvM[7:2], wel, 1'b0}));
	endtask : cmp_all

	// One host request, then the model steps and is compared
	task automatic issue(input amsrc_hcmd_t c, input logic [31:0] a,
		input logic [7:0] d, input amsrc_lanes_t l);
		logic [31:0] m;
		int          n;
		int          a0;
		a0 = addrSeen;
		reqValid <= 1'b1;
		reqCmd <= c;
		reqAddr <= a;
		reqData <= d;
		reqLanes <= l;
		ioLanes <= l;
		do @(posedge core_clk); while (!reqReady);
		reqValid <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (!done && n < 3000);
		chk("done", 32'(done), 32'h1);
		m = (fourB || c == HC_READ4) ? 32'hffffffff : 32'h00ffffff;
		case (c)
			HC_WREN: wel = 1'b1;
			HC_WRDI: wel = 1'b0;
			HC_EN4B: fourB = 1'b1;
			HC_EX4B: fourB = 1'b0;
			HC_RESET: begin
				fourB = 1'b0;
				xipM = 1'b0;
				wel = 1'b0;
			end
			HC_WRSR: begin
				nvM = d & SR_NV_MASK;
				wel = 1'b0;
			end
			HC_RDSR: chk("rdByte", 32'(rdByte),
				32'({nvM[7:2], wel, 1'b0}));
			HC_XIPEXIT: xipM = 1'b0;
			default: begin
				chk("addr", addrOut & m, a & m);
				chk("addrWide", 32'(addrWide), 32'(m[31]));
				chk("addrValid", 32'(addrSeen - a0), 32'h1);
				if (c == HC_XIP)
					xipM = 1'b1;
			end
		endcase
		cmp_all();
	endtask : issue

	task automatic power_up;
		rnd = lfsr(rnd);
		resetn <= 1'b0;
		nvStatusIn <= rnd[7:0];
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (5) @(posedge core_clk);
		nvM = rnd[7:0] & SR_NV_MASK;
		fourB = 1'b0;
		xipM = 1'b0;
		wel = 1'b0;
		cmp_all();
	endtask : power_up

	initial begin
		repeat (40000) @(posedge core_clk);
		errors++;
		close_out();
	end

	initial begin
		power_up();
		issue(HC_EN4B, 32'h0, 8'h0, LN1);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			issue(i[0] ? HC_READ4 : HC_READ, rnd, 8'h0, LN1);
			if (i == 1)
				issue(HC_EX4B, 32'h0, 8'h0, LN1);
		end
		$display("test address width done");
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			issue(HC_WRSR, 32'h0, rnd[7:0], LN1);
			issue(HC_RDSR, 32'h0, 8'h0, LN1);
		end
		issue(HC_WREN, 32'h0, 8'h0, LN1);
		issue(HC_RDSR, 32'h0, 8'h0, LN1);
		issue(HC_WRDI, 32'h0, 8'h0, LN1);
		$display("test status done");
		for (int i = 0; i < 3; i++) begin
			issue(HC_EN4B, 32'h0, 8'h0, LN1);
			issue(HC_WREN, 32'h0, 8'h0, LN1);
			issue(HC_RESET, 32'h0, 8'h0, amsrc_lanes_t'(i));
		end
		$display("test soft reset done");
		rnd = lfsr(rnd);
		issue(HC_XIP, rnd, 8'h0, LN1);
		issue(HC_XIP, ~rnd, 8'h0, LN1);
		issue(HC_XIPEXIT, 32'h0, 8'h0, LN1);
		issue(HC_EN4B, 32'h0, 8'h0, LN1);
		issue(HC_XIP, rnd, 8'h0, LN1);
		issue(HC_RESET, 32'h0, 8'h0, LN1);
		$display("test continuous read done");
		issue(HC_EN4B, 32'h0, 8'h0, LN1);
		issue(HC_WREN, 32'h0, 8'h0, LN1);
		hwResetN <= 1'b0;
		repeat (4) @(posedge core_clk);
		hwResetN <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("devFour", 32'(dFour), 32'h0);
		chk("status", 32'(statusOut), 32'({nvM[7:2], 2'b00}));
		wel = 1'b0;
		issue(HC_EX4B, 32'h0, 8'h0, LN1);
		$display("test hardware reset done");
		issue(HC_EN4B, 32'h0, 8'h0, LN1);
		power_up();
		$display("test power cycle done");
		close_out();
	end
endmodule : tb
